// File: verilog/mfc_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef MFC_MAP_SVH
`define MFC_MAP_SVH
`define MFC_ADDR_W 8
`define MFC_FLOW_OFS 8'h08
`define MFC_CFG_OFS 8'h10
`define MFC_STAT_OFS 8'h11
`define MFC_FLOW_RST 32'h0000_0000
`define MFC_CFG_RST 3'h0
`define MFC_BUSY_BIT 0
`define MFC_ON_BIT 1
`define MFC_PASS_BIT 2
`define MFC_PT_LSB 16
`define MFC_CFG_FD_BIT 0
`define MFC_CFG_TXEN_BIT 1
`define MFC_CFG_FAST_BIT 2
`define MFC_CLK_NS 10
`define MFC_SLOT_BITS 512
`define MFC_BIT_NS_FAST 10
`define MFC_BIT_NS_SLOW 100
`define MFC_SLOT_CYC_FAST (`MFC_SLOT_BITS * `MFC_BIT_NS_FAST / `MFC_CLK_NS)
`define MFC_SLOT_CYC_SLOW (`MFC_SLOT_BITS * `MFC_BIT_NS_SLOW / `MFC_CLK_NS)
`endif

// File: verilog/mfc_pkg.sv
// types shared by the flow control block
package mfc_pkg;
	typedef struct packed {
		logic is_pause;
		logic good;
		logic [15:0] quanta;
		logic filter_forced;
		logic filter_pass;
	} mfc_rx_info_type;
	typedef struct packed {
		logic valid;
		logic packet_filter;
	} mfc_rx_status_type;
	typedef struct packed {
		logic req;
		logic [15:0] pause_time;
	} mfc_tx_ctrl_type;
	typedef enum logic [1:0] {
		MFC_IDLE = 2'b00,
		MFC_SEND = 2'b01,
		MFC_BACKP = 2'b10
	} mfc_state_type;
endpackage

// File: verilog/mfc_flow_control.sv
// ethernet mac flow control: pause decode, pause send, back pressure
// Operation
// - pass flag set and valid pause received sets packet filter status
// - pass flag clear clears packet filter status of received frames
// - pause frames act only in full duplex with flow control on
// - every received frame is forwarded with a status word
// - address filtering modes override the pass flag
// - valid pause halts transmitter for pause value times slot time
// - flow control off means pause frames are not acted on; they still set packet filter status
// - in half duplex flow control on enables back pressure
// - busy flag high while pause frame or back pressure is sent
// - busy flag returns low when pause frame send completes
// - pause interval field goes into each sent pause frame
// - transmitter disabled means no pause frames and no back pressure
`include "mfc_map.svh"
`timescale 1ns/1ps
`default_nettype none
module mfc_flow_control #(
	parameter int SLOT_CYC_SLOW = `MFC_SLOT_CYC_SLOW
) (
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic [`MFC_ADDR_W-1:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	input wire logic rx_eof_i,
	input wire mfc_pkg::mfc_rx_info_type rx_info_i,
	output mfc_pkg::mfc_rx_status_type rx_status_o,
	input wire logic fc_request_i,
	input wire logic tx_pause_done_i,
	output mfc_pkg::mfc_tx_ctrl_type tx_ctrl_o,
	output logic backpressure_o,
	output logic tx_halt_o
);
	import mfc_pkg::*;

	localparam logic [12:0] SLOT_FAST = 13'(`MFC_SLOT_CYC_FAST);
	localparam logic [12:0] SLOT_SLOW = 13'(SLOT_CYC_SLOW);

	logic [15:0] pause_interval_value;
	logic pass_control_frames_flag;
	logic flow_ctrl_on;
	logic flow_ctrl_in_progress;
	logic [2:0] cfg;
	mfc_state_type state;
	mfc_state_type next_state;
	logic [15:0] quanta_left;
	logic [15:0] next_quanta;
	logic [12:0] slot_cnt;
	logic [12:0] next_slot;

	// register decode
	wire flow_sel = (addr_i == `MFC_FLOW_OFS);
	wire cfg_sel = (addr_i == `MFC_CFG_OFS);
	wire stat_sel = (addr_i == `MFC_STAT_OFS);
	wire full_duplex = cfg[`MFC_CFG_FD_BIT];
	wire tx_enable = cfg[`MFC_CFG_TXEN_BIT];
	wire fast_link = cfg[`MFC_CFG_FAST_BIT];
	wire [31:0] flow_word = {pause_interval_value, 13'h0000,
		pass_control_frames_flag, flow_ctrl_on, flow_ctrl_in_progress};
	wire [31:0] cfg_word = {29'h0000_0000, cfg};
	wire [31:0] stat_word = {quanta_left, 15'h0000, tx_halt_o};
	wire [31:0] next_rdata = !rd_i ? 32'h0000_0000 :
		flow_sel ? flow_word :
		cfg_sel ? cfg_word :
		stat_sel ? stat_word : 32'h0000_0000;

	// receive side status and pause decode
	wire pause_ok = rx_eof_i && rx_info_i.is_pause && rx_info_i.good;
	wire pause_act = pause_ok && full_duplex && flow_ctrl_on;
	wire next_pf = rx_info_i.filter_forced ? rx_info_i.filter_pass :
		(pass_control_frames_flag && pause_ok);

	// pause slot timing at the current link speed
	wire [12:0] slot_len = fast_link ? SLOT_FAST : SLOT_SLOW;
	wire slot_end = (slot_cnt == slot_len - 13'h0001);

	always_comb begin
		next_quanta = quanta_left;
		next_slot = slot_cnt;
		if (pause_act) begin
			next_quanta = rx_info_i.quanta;
			next_slot = 13'h0000;
		end else if (quanta_left != 16'h0000) begin
			if (slot_end) begin
				next_slot = 13'h0000;
				next_quanta = quanta_left - 16'h0001;
			end else begin
				next_slot = slot_cnt + 13'h0001;
			end
		end
	end

	// transmit side: pause frame in full duplex, back pressure in half
	wire may_send = tx_enable && flow_ctrl_on && fc_request_i;
	always_comb begin
		next_state = state;
		case (state)
			MFC_IDLE: begin
				if (may_send && full_duplex) begin
					next_state = MFC_SEND;
				end else if (may_send && !full_duplex) begin
					next_state = MFC_BACKP;
				end
			end
			MFC_SEND: begin
				if (tx_pause_done_i) begin
					next_state = MFC_IDLE;
				end
			end
			MFC_BACKP: begin
				if (!may_send || full_duplex) begin
					next_state = MFC_IDLE;
				end
			end
			default: begin
				next_state = MFC_IDLE;
			end
		endcase
	end
	wire start_send = (state == MFC_IDLE) && (next_state == MFC_SEND);

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pause_interval_value <= 16'(`MFC_FLOW_RST >> `MFC_PT_LSB);
			pass_control_frames_flag <= 1'b0;
			flow_ctrl_on <= 1'b0;
			cfg <= `MFC_CFG_RST;
		end else if (wr_i && flow_sel) begin
			// busy bit is hardware owned, written value ignored
			pause_interval_value <= wdata_i[31:`MFC_PT_LSB];
			pass_control_frames_flag <= wdata_i[`MFC_PASS_BIT];
			flow_ctrl_on <= wdata_i[`MFC_ON_BIT];
		end else if (wr_i && cfg_sel) begin
			cfg <= wdata_i[2:0];
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rdata_o <= 32'h0000_0000;
			rx_status_o <= '0;
			quanta_left <= 16'h0000;
			slot_cnt <= 13'h0000;
			tx_halt_o <= 1'b0;
		end else begin
			rdata_o <= next_rdata;
			rx_status_o.valid <= rx_eof_i;
			rx_status_o.packet_filter <= rx_eof_i && next_pf;
			quanta_left <= next_quanta;
			slot_cnt <= next_slot;
			tx_halt_o <= (next_quanta != 16'h0000);
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state <= MFC_IDLE;
			flow_ctrl_in_progress <= 1'b0;
			tx_ctrl_o <= '0;
			backpressure_o <= 1'b0;
		end else begin
			state <= next_state;
			flow_ctrl_in_progress <= (next_state != MFC_IDLE);
			tx_ctrl_o.req <= start_send;
			if (start_send) begin
				tx_ctrl_o.pause_time <= pause_interval_value;
			end
			backpressure_o <= (next_state == MFC_BACKP);
		end
	end

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rstn_i);

	pass_flag_set_a: assert property (
		pause_ok && pass_control_frames_flag && !rx_info_i.filter_forced
		|=> rx_status_o.packet_filter)
		else $error("pause frame not flagged with pass set");
	pass_flag_clr_a: assert property (
		rx_eof_i && !pass_control_frames_flag
		&& !rx_info_i.filter_forced |=> !rx_status_o.packet_filter)
		else $error("packet filter set with pass clear");
	pause_gate_a: assert property (
		!tx_halt_o && !(full_duplex && flow_ctrl_on) |=> !tx_halt_o)
		else $error("pause honoured outside full duplex with flow on");
	status_every_a: assert property (
		rx_eof_i |=> rx_status_o.valid)
		else $error("frame status missing");
	filter_over_a: assert property (
		rx_eof_i && rx_info_i.filter_forced
		|=> rx_status_o.packet_filter == $past(rx_info_i.filter_pass))
		else $error("filter mode did not override pass flag");
	pause_load_a: assert property (
		pause_act && rx_info_i.quanta != 16'h0000
		|=> tx_halt_o && quanta_left == $past(rx_info_i.quanta))
		else $error("pause value not loaded");
	quanta_step_a: assert property (
		quanta_left > 16'h0001 && slot_end && !pause_act
		|=> quanta_left == $past(quanta_left) - 16'h0001 && tx_halt_o)
		else $error("pause quanta did not step at slot end");
	slot_bound_a: assert property (
		quanta_left != 16'h0000 |-> slot_cnt < slot_len)
		else $error("slot counter beyond slot length");
	no_decode_a: assert property (
		!flow_ctrl_on && !tx_halt_o |=> !tx_halt_o)
		else $error("pause decoded with flow control off");
	bp_half_a: assert property (
		backpressure_o |-> !$past(full_duplex) && $past(flow_ctrl_on)
		&& flow_ctrl_in_progress)
		else $error("back pressure outside half duplex");
	busy_send_a: assert property (
		tx_ctrl_o.req |-> flow_ctrl_in_progress ##1 flow_ctrl_in_progress)
		else $error("busy low while pause frame pending");
	busy_end_a: assert property (
		state == MFC_SEND && tx_pause_done_i |=> !flow_ctrl_in_progress)
		else $error("busy not released after pause frame");
	pause_value_a: assert property (
		tx_ctrl_o.req |-> tx_ctrl_o.pause_time
		== $past(pause_interval_value))
		else $error("wrong pause time in sent frame");
	tx_off_a: assert property (
		!tx_enable && state == MFC_IDLE
		|=> !tx_ctrl_o.req && !backpressure_o)
		else $error("flow control sent with transmitter off");

	// register bus, busy flag, slot timing and send gating checks
	rdata_idle_a: assert property (
		!rd_i
		|=> rdata_o == 32'h0000_0000)
		else $error("read data not cleared outside read answer");
	busy_read_a: assert property (
		rd_i && flow_sel
		|=> rdata_o[`MFC_BUSY_BIT] == $past(flow_ctrl_in_progress))
		else $error("busy bit not returned on read");
	flow_read_a: assert property (
		rd_i && flow_sel
		|=> rdata_o[31:`MFC_PT_LSB] == $past(pause_interval_value))
		else $error("pause interval not returned on read");
	flow_write_a: assert property (
		wr_i && flow_sel
		|=> pause_interval_value == $past(wdata_i[31:`MFC_PT_LSB]))
		else $error("pause interval write lost");
	busy_state_a: assert property (
		state != MFC_IDLE
		|-> flow_ctrl_in_progress)
		else $error("busy low while sending or back pressure");
	busy_hold_a: assert property (
		state == MFC_SEND && !tx_pause_done_i
		|=> flow_ctrl_in_progress && state == MFC_SEND)
		else $error("busy dropped before pause frame finished");
	idle_busy_a: assert property (
		state == MFC_IDLE && next_state == MFC_IDLE
		|=> !flow_ctrl_in_progress)
		else $error("busy high while idle");
	status_quiet_a: assert property (
		!rx_eof_i
		|=> !rx_status_o.valid && !rx_status_o.packet_filter)
		else $error("frame status without a frame");
	pause_cancel_a: assert property (
		pause_act && rx_info_i.quanta == 16'h0000
		|=> !tx_halt_o && quanta_left == 16'h0000)
		else $error("zero pause did not release transmitter");
	halt_hold_a: assert property (
		quanta_left > 16'h0001 && !pause_act
		|=> tx_halt_o)
		else $error("transmitter released with pause left");
	slot_step_a: assert property (
		quanta_left != 16'h0000 && !slot_end && !pause_act
		|=> slot_cnt == $past(slot_cnt) + 13'h0001)
		else $error("slot counter did not advance");
	halt_end_a: assert property (
		quanta_left == 16'h0001 && slot_end && !pause_act
		|=> !tx_halt_o)
		else $error("transmitter held after last pause slot");
	req_pulse_a: assert property (
		tx_ctrl_o.req
		|=> !tx_ctrl_o.req)
		else $error("pause frame request longer than one cycle");
	req_gate_a: assert property (
		tx_ctrl_o.req |-> $past(tx_enable) && $past(flow_ctrl_on)
		&& $past(full_duplex))
		else $error("pause frame requested when not allowed");
	bp_start_a: assert property (
		state == MFC_IDLE && may_send && !full_duplex
		|=> backpressure_o && flow_ctrl_in_progress)
		else $error("back pressure not started in half duplex");
	bp_drop_a: assert property (
		backpressure_o && !may_send
		|=> !backpressure_o)
		else $error("back pressure held without request");
	time_hold_a: assert property (
		!start_send
		|=> $stable(tx_ctrl_o.pause_time))
		else $error("pause time changed without a new frame");
	tx_off_bp_a: assert property (
		!tx_enable
		|=> !tx_ctrl_o.req && !backpressure_o)
		else $error("flow control active with transmitter off");
	fd_no_bp_a: assert property (
		full_duplex
		|=> !backpressure_o)
		else $error("back pressure started in full duplex");
endmodule
`default_nettype wire

// File: dv/mfc_link_model.sv
// link partner model: ends each requested pause frame after a delay
`timescale 1ns/1ps
`default_nettype none
module mfc_link_model #(
	parameter int DELAY = 20
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire mfc_pkg::mfc_tx_ctrl_type tx_ctrl_i,
	output logic done_o
);
	import mfc_pkg::*;
	int cnt;
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt <= 0;
			done_o <= 1'b0;
		end else begin
			done_o <= (cnt == 1);
			if (tx_ctrl_i.req)
				cnt <= DELAY;
			else if (cnt != 0)
				cnt <= cnt - 1;
		end
	end
endmodule
`default_nettype wire

// File: dv/tb_top.sv
// flow control testbench: register, receive and transmit checks
`include "mfc_map.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import mfc_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] rdata;
	logic eof = 1'b0;
	mfc_rx_info_type info = '0;
	mfc_rx_status_type st;
	logic fcr = 1'b0;
	logic done;
	mfc_tx_ctrl_type txc;
	logic bp;
	logic halt;
	logic seen;
	int err_count = 0;
	int cmp_count = 0;
	int cyc = 0;
	mfc_flow_control #(.SLOT_CYC_SLOW(16)) uut (.ref_clk_i(clk),
		.rstn_i(rstn), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
		.rd_i(rd), .rdata_o(rdata), .rx_eof_i(eof), .rx_info_i(info),
		.rx_status_o(st), .fc_request_i(fcr), .tx_pause_done_i(done),
		.tx_ctrl_o(txc), .backpressure_o(bp), .tx_halt_o(halt));
	mfc_link_model lm (.clk_i(clk), .rstn_i(rstn), .tx_ctrl_i(txc),
		.done_o(done));
	initial begin
		forever #5 clk = ~clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic complete_run;
		$display("errors=%0d compares=%0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			complete_run();
		end
	end
	task automatic wrt(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, e);
	endtask
	task automatic rx(input logic [19:0] i, input logic pf);
		@(posedge clk);
		eof <= 1'b1;
		info <= i;
		@(posedge clk);
		eof <= 1'b0;
		#1;
		chk({30'h0, st}, {30'h0, 1'b1, pf});
	endtask
	task automatic hold(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		rdc(`MFC_FLOW_OFS, 32'h0);
		rdc(`MFC_CFG_OFS, 32'h0);
		rdc(8'h33, 32'h0);
		wrt(`MFC_FLOW_OFS, 32'habcd_0004);
		rdc(`MFC_FLOW_OFS, 32'habcd_0004);
		wrt(`MFC_CFG_OFS, 32'h3);
		rx(20'hc0008, 1'b1);
		chk({31'h0, halt}, 32'h0);
		rx(20'h00003, 1'b1);
		rdc(`MFC_FLOW_OFS, 32'habcd_0004);
		wrt(`MFC_FLOW_OFS, 32'habcd_0002);
		rx(20'hc0008, 1'b0);
		chk({31'h0, halt}, 32'h1);
		rdc(`MFC_STAT_OFS, 32'h0002_0001);
		hold(29);
		chk({31'h0, halt}, 32'h1);
		hold(1);
		chk({31'h0, halt}, 32'h0);
		wrt(`MFC_CFG_OFS, 32'h2);
		rx(20'hc0008, 1'b0);
		chk({31'h0, halt}, 32'h0);
		wrt(`MFC_CFG_OFS, 32'h3);
		@(posedge clk);
		fcr <= 1'b1;
		repeat (10) begin
			@(posedge clk);
			#1;
			if (txc.req === 1'b1)
				break;
		end
		chk({31'h0, txc.req}, 32'h1);
		chk({16'h0, txc.pause_time}, 32'habcd);
		@(posedge clk);
		fcr <= 1'b0;
		rdc(`MFC_FLOW_OFS, 32'habcd_0003);
		hold(25);
		rdc(`MFC_FLOW_OFS, 32'habcd_0002);
		wrt(`MFC_CFG_OFS, 32'h2);
		@(posedge clk);
		fcr <= 1'b1;
		hold(3);
		chk({31'h0, bp}, 32'h1);
		rdc(`MFC_FLOW_OFS, 32'habcd_0003);
		@(posedge clk);
		fcr <= 1'b0;
		hold(3);
		chk({31'h0, bp}, 32'h0);
		wrt(`MFC_CFG_OFS, 32'h7);
		rx(20'hc0004, 1'b0);
		hold(`MFC_SLOT_CYC_FAST - 1);
		chk({31'h0, halt}, 32'h1);
		hold(1);
		chk({31'h0, halt}, 32'h0);
		rx(20'hc0008, 1'b0);
		rx(20'hc0000, 1'b0);
		chk({31'h0, halt}, 32'h0);
		wrt(`MFC_CFG_OFS, 32'h1);
		@(posedge clk);
		fcr <= 1'b1;
		seen = 1'b0;
		repeat (30) begin
			@(posedge clk);
			#1;
			seen = seen | txc.req | bp;
		end
		chk({31'h0, seen}, 32'h0);
		rdc(`MFC_FLOW_OFS, 32'habcd_0002);
		complete_run();
	end
endmodule
`default_nettype wire
